// ---- hdl/adc_serial_ctrl.sv ----
// Serial configuration capture and output word framing of the converter
// Behaviour
// R1: Enable bit then seven config bits; clear keeps
// R2: Gain code maps per speed mode
// R3: Rejection code 00 both, 01 50Hz, 10 60Hz
// R4: Reset: external input, gain 1, both, normal
// R5: Selected gain scales full-scale span inversely
// R6: Temperature select converts on-chip sensor
// R7: Temperature forces gain 1 and normal speed
// R8: Default both rejections, or single frequency
// R9: Normal speed calibrates; double speed skips it
// R10: Every word from its own single conversion
// R11: Word: three status, 17 result, four config
// R12: Extra clocks ignored during conversion, output one
// R13: Chip select high aborts, starts conversion
// R14: Done flag high converting, low when complete
// R15: Filler bit always low
// R16: Polarity bit high for positive input
// R17: Polarity may toggle at zero in double speed
// R18: Over/underrange flags and clamped codes
// R19: Bits 20 to 4 two's-complement result
// R20: Config echo: gain bits and temperature select
// R21: Chip select high: output off, clocks ignored
// R22: Done flag shown live while selected
// R23: Bit 23 first, shift on falling edges
// R24: 24th falling edge drives output high
// R25: Config sampled on rising edges, enable first
// R26: New config applies to next conversion
`timescale 1ns/1ps
module adc_serial_ctrl (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic serial_in,
   input wire logic conv_done,
   input wire adc_pkg::result_t conv_result,
   output logic serial_out,
   output logic serial_out_oe,
   output logic conv_start,
   output adc_pkg::cfg_t cfg_active,
   output logic [3:0] gain_log2,
   output logic autocal_en
);

   logic [2:0] pins_s;
   logic cs_n_s;
   logic sck_s;
   logic sdi_s;
   logic sck_d_r;
   logic sck_rise;
   logic sck_fall;
   logic sel;

   adc_pkg::conv_state_t state_r;
   logic [adc_pkg::WORD_BITS-1:0] shift_r;
   logic [4:0] fall_cnt_r;
   logic [3:0] rise_cnt_r;
   logic [adc_pkg::CFG_BITS-1:0] cfg_sr_r;
   logic [adc_pkg::CFG_BITS-1:0] cfg_aligned;
   adc_pkg::cfg_t cfg_nxt;
   logic [adc_pkg::WORD_BITS-1:0] word_nxt;
   logic last_fall;
   logic abort;

   pin_sync #(
      .WIDTH(3),
      .RST_VAL(adc_pkg::PIN_RST)
   ) u_pin_sync (
      .clk(core_clk),
      .rst_n(rst_n),
      .d({cs_n, sck, serial_in}),
      .q(pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sck_s = pins_s[1];
   assign sdi_s = pins_s[0];
   assign sel = ~cs_n_s;
   assign sck_rise = sck_s & ~sck_d_r;
   assign sck_fall = ~sck_s & sck_d_r;
   // Edges only count while selected and in the output phase
   assign last_fall = (state_r == adc_pkg::ST_OUTPUT) && sel && sck_fall
                      && (fall_cnt_r == adc_pkg::LAST_FALL); // R23
   assign abort = (state_r == adc_pkg::ST_OUTPUT) && cs_n_s; // R13

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_d_r <= 1'b0;
      end else begin
         sck_d_r <= sck_s;
      end
   end

   // Missing trailing bits of a short write read as zero
   assign cfg_aligned = cfg_sr_r << (adc_pkg::CFG_EDGES - rise_cnt_r); // R1

   always_comb begin
      cfg_nxt = cfg_active;
      if (rise_cnt_r != 4'h0 && cfg_aligned[7]) begin // R1
         cfg_nxt.gain = cfg_aligned[6:4];
         cfg_nxt.temp_input_select = cfg_aligned[3]; // R6
         cfg_nxt.reject_select_a = cfg_aligned[2]; // R3
         cfg_nxt.reject_select_b = cfg_aligned[1]; // R8
         cfg_nxt.double_speed_select = cfg_aligned[0];
      end
      if (cfg_nxt.temp_input_select) begin // R7
         cfg_nxt.gain = 3'h0;
         cfg_nxt.double_speed_select = 1'b0;
      end
   end

   // Result word framed from the conversion that just finished
   always_comb begin
      word_nxt = '0;
      word_nxt[adc_pkg::EOC_POS] = 1'b0; // R14
      word_nxt[adc_pkg::FILL_POS] = 1'b0; // R15
      word_nxt[adc_pkg::POL_POS] = conv_result.polarity; // R16 R17
      word_nxt[adc_pkg::RES_MSB:adc_pkg::RES_LSB] = conv_result.value; // R19
      if (conv_result.over) begin // R18
         word_nxt[adc_pkg::POL_POS] = 1'b1;
         word_nxt[adc_pkg::RES_MSB:adc_pkg::RES_LSB] = adc_pkg::OVER_CODE;
      end else if (conv_result.under) begin // R18
         word_nxt[adc_pkg::POL_POS] = 1'b0;
         word_nxt[adc_pkg::RES_MSB:adc_pkg::RES_LSB] = adc_pkg::UNDER_CODE;
      end
      word_nxt[3:0] = {cfg_active.gain, cfg_active.temp_input_select}; // R20 R11
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= adc_pkg::ST_LAUNCH;
      end else begin
         case (state_r)
            adc_pkg::ST_LAUNCH: begin
               state_r <= adc_pkg::ST_CONVERT;
            end
            adc_pkg::ST_CONVERT: begin
               if (conv_done) begin // R14
                  state_r <= adc_pkg::ST_SLEEP;
               end
            end
            adc_pkg::ST_SLEEP: begin
               if (sel) begin
                  state_r <= adc_pkg::ST_OUTPUT;
               end
            end
            adc_pkg::ST_OUTPUT: begin
               if (abort || last_fall) begin // R13 R24
                  state_r <= adc_pkg::ST_LAUNCH;
               end
            end
            default: begin
               state_r <= adc_pkg::ST_LAUNCH;
            end
         endcase
      end
   end

   // Output shift register; ones shift in behind the word
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= '1;
      end else if (state_r == adc_pkg::ST_CONVERT && conv_done) begin
         shift_r <= word_nxt; // R10
      end else if (state_r == adc_pkg::ST_OUTPUT && sel && sck_fall) begin
         shift_r <= {shift_r[adc_pkg::WORD_BITS-2:0], 1'b1}; // R23
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fall_cnt_r <= 5'h00;
      end else if (state_r != adc_pkg::ST_OUTPUT) begin
         fall_cnt_r <= 5'h00;
      end else if (sel && sck_fall) begin
         fall_cnt_r <= fall_cnt_r + 5'h01;
      end
   end

   // Configuration sampled on the first eight rising edges
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rise_cnt_r <= 4'h0;
         cfg_sr_r <= 8'h00;
      end else if (state_r != adc_pkg::ST_OUTPUT) begin
         rise_cnt_r <= 4'h0;
         cfg_sr_r <= 8'h00;
      end else if (sel && sck_rise && rise_cnt_r != adc_pkg::CFG_EDGES) begin
         rise_cnt_r <= rise_cnt_r + 4'h1; // R25
         cfg_sr_r <= {cfg_sr_r[6:0], sdi_s};
      end
   end

   // Config is switched only at a conversion start
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_active <= adc_pkg::CFG_RST; // R4
         gain_log2 <= 4'h0;
         autocal_en <= 1'b1;
      end else if (state_r == adc_pkg::ST_OUTPUT && (abort || last_fall)) begin
         cfg_active <= cfg_nxt; // R26
         autocal_en <= ~cfg_nxt.double_speed_select; // R9
         // Span divides by this power of two
         if (cfg_nxt.double_speed_select || cfg_nxt.gain == 3'h0) begin // R2 R5
            gain_log2 <= {1'b0, cfg_nxt.gain};
         end else begin
            gain_log2 <= {1'b0, cfg_nxt.gain} + 4'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_start <= 1'b0;
      end else begin
         conv_start <= (state_r == adc_pkg::ST_LAUNCH);
      end
   end

   // Converting reads as one; extra clocks land here harmlessly
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_out <= 1'b1;
         serial_out_oe <= 1'b0;
      end else begin
         serial_out_oe <= sel; // R21
         if (state_r == adc_pkg::ST_SLEEP || state_r == adc_pkg::ST_OUTPUT) begin
            serial_out <= shift_r[adc_pkg::WORD_BITS-1]; // R22
         end else begin
            serial_out <= 1'b1; // R12 R14
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_last_edge;
      last_fall;
   endsequence

   sequence s_relaunch;
      state_r == adc_pkg::ST_LAUNCH ##1 conv_start && serial_out;
   endsequence

   sequence s_load;
      state_r == adc_pkg::ST_CONVERT && conv_done;
   endsequence

   property p_busy_high;
      state_r == adc_pkg::ST_CONVERT |=> serial_out;
   endproperty
   a_busy_high: assert property (p_busy_high) else $error("busy flag not high"); // R14

   property p_done_live;
      state_r == adc_pkg::ST_SLEEP && sel |=> !serial_out && serial_out_oe;
   endproperty
   a_done_live: assert property (p_done_live) else $error("done flag not low"); // R22

   property p_deselect_off;
      cs_n_s |=> !serial_out_oe;
   endproperty
   a_deselect_off: assert property (p_deselect_off) else $error("output enabled"); // R21

   property p_last_edge;
      s_last_edge |=> s_relaunch;
   endproperty
   a_last_edge: assert property (p_last_edge) else $error("no restart at end"); // R24

   property p_abort;
      abort |=> s_relaunch;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not restart"); // R13

   property p_temp_force;
      cfg_active.temp_input_select |-> cfg_active.gain == 3'h0
         && !cfg_active.double_speed_select && gain_log2 == 4'h0 && autocal_en;
   endproperty
   a_temp_force: assert property (p_temp_force) else $error("temp mode not forced"); // R7

   property p_status_bits;
      s_load |=> shift_r[23:22] == 2'h0;
   endproperty
   a_status_bits: assert property (p_status_bits) else $error("status bits wrong"); // R15

   property p_over;
      s_load ##0 conv_result.over |=> shift_r[21:4] == 18'h30000;
   endproperty
   a_over: assert property (p_over) else $error("overrange code wrong"); // R18

   property p_under;
      s_load ##0 (conv_result.under && !conv_result.over) |=> shift_r[21:4] == 18'h0FFFF;
   endproperty
   a_under: assert property (p_under) else $error("underrange code wrong"); // R18

   property p_echo;
      s_load |=> shift_r[3:0] == {cfg_active.gain, cfg_active.temp_input_select};
   endproperty
   a_echo: assert property (p_echo) else $error("config echo wrong"); // R20

   property p_result;
      s_load ##0 !(conv_result.over || conv_result.under)
         |=> shift_r[20:4] == $past(conv_result.value);
   endproperty
   a_result: assert property (p_result) else $error("result field wrong"); // R19

   property p_hold_cfg;
      state_r != adc_pkg::ST_OUTPUT |=> $stable(cfg_active);
   endproperty
   a_hold_cfg: assert property (p_hold_cfg) else $error("config changed early"); // R26

   property p_shift;
      state_r == adc_pkg::ST_OUTPUT && sel && sck_fall
         |=> shift_r[23:1] == $past(shift_r[22:0]);
   endproperty
   a_shift: assert property (p_shift) else $error("shift step wrong"); // R23

   property p_desel_hold;
      cs_n_s && !(state_r == adc_pkg::ST_CONVERT && conv_done) |=> $stable(shift_r);
   endproperty
   a_desel_hold: assert property (p_desel_hold) else $error("shifted while off"); // R21

   property p_extra_one;
      state_r == adc_pkg::ST_CONVERT && sck_fall |=> serial_out && fall_cnt_r == 5'h00;
   endproperty
   a_extra_one: assert property (p_extra_one) else $error("extra clock not ignored"); // R12

   property p_cfg_sample;
      state_r == adc_pkg::ST_OUTPUT && sel && sck_rise && rise_cnt_r != adc_pkg::CFG_EDGES
         |=> cfg_sr_r[0] == $past(sdi_s);
   endproperty
   a_cfg_sample: assert property (p_cfg_sample) else $error("config bit not taken"); // R25

   property p_gain_double;
      cfg_active.double_speed_select |-> gain_log2 == {1'b0, cfg_active.gain};
   endproperty
   a_gain_double: assert property (p_gain_double) else $error("double speed gain wrong"); // R2

   property p_speed_cal;
      autocal_en != cfg_active.double_speed_select;
   endproperty
   a_speed_cal: assert property (p_speed_cal) else $error("calibration mode wrong"); // R9

endmodule

// ---- hdl/adc_pkg.sv ----
// Shared constants and types for the converter serial control block
package adc_pkg;

   localparam int WORD_BITS = 24;
   localparam int RES_BITS = 17;
   localparam int CFG_BITS = 8;

   // Field positions inside the output word
   localparam int EOC_POS = 23;
   localparam int FILL_POS = 22;
   localparam int POL_POS = 21;
   localparam int RES_MSB = 20;
   localparam int RES_LSB = 4;

   // Edge counts of the data output phase
   localparam logic [4:0] LAST_FALL = 5'h17;
   localparam logic [3:0] CFG_EDGES = 4'h8;

   // Clamp codes for out-of-range inputs, value field only
   localparam logic [RES_BITS-1:0] OVER_CODE = 17'h10000;
   localparam logic [RES_BITS-1:0] UNDER_CODE = 17'h0FFFF;

   // Rejection encodings
   localparam logic [1:0] REJ_BOTH = 2'h0;
   localparam logic [1:0] REJ_50 = 2'h1;
   localparam logic [1:0] REJ_60 = 2'h2;

   // Pin synchroniser reset: chip select idle high, clock and data low
   localparam logic [2:0] PIN_RST = 3'h4;

   typedef struct packed {
      logic [2:0] gain;
      logic temp_input_select;
      logic reject_select_a;
      logic reject_select_b;
      logic double_speed_select;
   } cfg_t;

   localparam cfg_t CFG_RST = '{gain: 3'h0, temp_input_select: 1'b0, reject_select_a: 1'b0,
                                reject_select_b: 1'b0, double_speed_select: 1'b0};

   typedef struct packed {
      logic over;
      logic under;
      logic polarity;
      logic [RES_BITS-1:0] value;
   } result_t;

   typedef enum logic [1:0] {
      ST_LAUNCH,
      ST_CONVERT,
      ST_SLEEP,
      ST_OUTPUT
   } conv_state_t;

endpackage

// ---- hdl/pin_sync.sv ----
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

// ---- tb/mcu_model.sv ----
// Behavioural microcontroller driving chip select, serial clock and config data
`timescale 1ns/1ps
module mcu_model (
   output logic cs_n,
   output logic sck,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe
);
   // 125 ns link clock, each half period exactly 25 core clock half periods
   localparam realtime HALF = 62.5;

   // Undriven line reads as the inverse so a stale value cannot pass
   logic sdo_line;
   assign sdo_line = serial_out_oe ? serial_out : ~serial_out;

   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      serial_in = 1'b0;
   end

   task automatic select();
      cs_n = 1'b0;
   endtask

   // Clock idles low; xfer runs it only inside the frame, pulse only outside it
   task automatic xfer(input logic [7:0] cfg, input int n, input int stop,
                       output logic [31:0] w);
      w = '0;
      for (int i = 0; i < n && i < stop; i++) begin
         serial_in = (i < 8) ? cfg[7 - i] : 1'b0;
         #HALF sck = 1'b1;
         w = {w[30:0], sdo_line};
         #HALF sck = 1'b0;
      end
      #HALF cs_n = 1'b1;
      serial_in = 1'b0;
   endtask

   task automatic pulse(input int k);
      repeat (k) begin
         #HALF sck = 1'b1;
         #HALF sck = 1'b0;
      end
   endtask
endmodule

// ---- tb/adc_serial_ctrl_test.sv ----
// Self-checking bench for the converter serial control block
`timescale 1ns/1ps
module adc_serial_ctrl_test;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic conv_done = 1'b0;
   logic busy = 1'b0;
   adc_pkg::result_t conv_result = '0;
   adc_pkg::result_t cur_res = '0;
   adc_pkg::cfg_t exp_cfg = adc_pkg::CFG_RST;
   adc_pkg::cfg_t conv_cfg = adc_pkg::CFG_RST;
   logic cs_n, sck, serial_in, serial_out, serial_out_oe, conv_start, autocal_en;
   adc_pkg::cfg_t cfg_active;
   logic [3:0] gain_log2;
   logic [31:0] seed = 32'h0000000B;
   logic [31:0] r, c;
   int starts = 0;
   int compares = 0;
   int miscompares = 0;

   always #2.5 core_clk = ~core_clk;

   adc_serial_ctrl i_adc_serial_ctrl (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n),
      .sck(sck), .serial_in(serial_in), .conv_done(conv_done), .conv_result(conv_result),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe), .conv_start(conv_start),
      .cfg_active(cfg_active), .gain_log2(gain_log2), .autocal_en(autocal_en));

   mcu_model i_mcu_model (.cs_n(cs_n), .sck(sck), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_oe(serial_out_oe));

   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic adc_pkg::cfg_t eff(adc_pkg::cfg_t x);
      if (x.temp_input_select) begin
         x.gain = 3'h0;
         x.double_speed_select = 1'b0;
      end
      return x;
   endfunction

   function automatic logic [3:0] glog(adc_pkg::cfg_t x);
      if (x.double_speed_select) return {1'b0, x.gain};
      return (x.gain == 3'h0) ? 4'h0 : {1'b0, x.gain} + 4'h1;
   endfunction

   function automatic logic [23:0] exp_word(adc_pkg::result_t q, adc_pkg::cfg_t x);
      logic p;
      logic [16:0] v;
      p = q.over | (~q.under & q.polarity);
      v = q.over ? 17'h10000 : (q.under ? 17'h0FFFF : q.value);
      return {2'b00, p, v, x.gain, x.temp_input_select};
   endfunction

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   // Converter core stand-in; long conversions keep extra clocks inside one
   always begin
      @(posedge core_clk iff conv_start === 1'b1);
      busy = 1'b1;
      starts++;
      repeat (300 + rnd() % 64) @(posedge core_clk);
      r = rnd();
      r[19] = r[19] & (r[22:21] == 2'h0);
      r[18] = r[18] & (r[24:23] == 2'h0);
      #1 conv_done = 1'b1;
      busy = 1'b0;
      conv_result = adc_pkg::result_t'(r[19:0]);
      cur_res = conv_result;
      conv_cfg = eff(exp_cfg);
      @(posedge core_clk);
      #1 conv_done = 1'b0;
   end

   task automatic frame(input logic [7:0] cfg, input int n, input int stop);
      logic [31:0] w;
      logic [23:0] e;
      adc_pkg::cfg_t x;
      int k;
      chk_bit(serial_out_oe, 1'b0);
      i_mcu_model.select();
      repeat (8) @(posedge core_clk);
      #1;
      chk_bit(serial_out_oe, 1'b1);
      if (busy) chk_bit(serial_out, 1'b1);
      k = 0;
      while (serial_out !== 1'b0 && k < 500) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      chk_bit(busy, 1'b0);
      e = exp_word(cur_res, conv_cfg);
      k = starts;
      i_mcu_model.xfer(cfg, n, stop, w);
      if (stop < 24) begin
         chk_word(w, 32'(e >> (24 - stop)));
      end else begin
         chk_bit(serial_out, 1'b1);
         chk_word(w >> (n - 24), 32'(e));
         chk_word(w & ((32'h1 << (n - 24)) - 1), (32'h1 << (n - 24)) - 1);
      end
      if (cfg[7] && stop >= 8) exp_cfg = adc_pkg::cfg_t'(cfg[6:0]);
      x = eff(exp_cfg);
      repeat (20) @(posedge core_clk);
      #1;
      chk_bit(starts == k + 1, 1'b1);
      chk_word(32'(cfg_active), 32'(x));
      chk_word(32'({gain_log2, autocal_en}), 32'({glog(x), ~x.double_speed_select}));
   endtask

   task automatic final_report();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #400us;
      miscompares++;
      final_report();
   end

   initial begin
      repeat (4) @(posedge core_clk);
      chk_word(32'(cfg_active), 32'(adc_pkg::CFG_RST));
      chk_word(32'({gain_log2, autocal_en}), 32'h1);
      #1 rst_n = 1'b1;
      frame(8'h00, 24, 24);
      for (int i = 0; i < 16; i++) begin
         frame({1'b1, i[2:0], 3'h0, i[3]}, 24, 24);
      end
      for (int i = 0; i < 3; i++) begin
         frame({4'hF, 1'b1, i[1:0], 1'b1}, 24, 24);
      end
      frame(8'hC5, 32, 32);
      frame(8'h5A, 24, 10);
      for (int i = 0; i < 10; i++) begin
         c = rnd();
         // Reserved rejection code never sent
         c[1] = c[1] & ~c[2];
         i_mcu_model.pulse(int'(c[9:8]));
         frame(c[7:0], 24 + 8 * int'(c[10]), 24 + 8 * int'(c[10]));
      end
      final_report();
   end
endmodule
